// ---- lpmc_ctrl.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ns
// Notes on behaviour
// - no deep select: sleep or subsleep
// - deep select: standby/watch, subactive goes watch
// - standby wake, and watch wake with slow bit clear, hold cpu through settling
// - wait codes 000=8192, 001=16384 states
// - wait codes 010=1024, 011=2048, 100=4096
// - wait codes 101=2, 110=8, 111=16
// - watch exit, slow bit clear: main clock
// - watch exit, slow bit set: subclock
module lpmc_ctrl
    import lpmc_pkg::*;
#(
    parameter int WAIT_000 = WAIT_000_CYC,
    parameter int WAIT_001 = WAIT_001_CYC
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // register port
    input  wire lpmc_bus_req_s bus_req,
    output logic [7:0]         rdata,
    // core events
    input  wire logic          sleep_exec,
    input  wire logic          wake_irq,
    input  wire logic          watch_enable,
    // power state
    output lpmc_mode_e         mode,
    output lpmc_ctrl_s         ctrl
);

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [7:0]       pmc;
    logic [7:0]       next_pmc;
    logic [7:0]       next_rdata;

    lpmc_mode_e       next_mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0]       wait_sel_q;
    logic [2:0]       next_wait_sel_q;
    logic             slow_q;
    logic             next_slow_q;
    lpmc_ctrl_s       next_ctrl;

    logic             deep_sel;
    logic [2:0]       wait_sel;
    logic             slow_sel;

    assign deep_sel = pmc[DEEP_SLEEP_BIT];
    assign wait_sel = pmc[WAIT_SEL_HI_BIT:WAIT_SEL_LO_BIT];
    assign slow_sel = pmc[SLOW_ON_WAKE_BIT];

    function automatic logic [CNT_W-1:0] wait_load(input logic [2:0] s);
        int n;
        n = 1;
        unique case (s)
            3'h0: n = WAIT_000;
            3'h1: n = WAIT_001;
            3'h2: n = WAIT_010_CYC;
            3'h3: n = WAIT_011_CYC;
            3'h4: n = WAIT_100_CYC;
            3'h5: n = WAIT_101_CYC;
            3'h6: n = WAIT_110_CYC;
            3'h7: n = WAIT_111_CYC;
        endcase
        if (n < 1) begin
            n = 1;
        end
        wait_load = CNT_W'(n - 1);
    endfunction : wait_load

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    always_comb begin
        next_pmc   = pmc;
        next_rdata = 8'h00;
        if (bus_req.wr && bus_req.addr == PMC_OFFSET) begin
            next_pmc      = bus_req.wdata;
            next_pmc[2:0] = 3'h0;
        end
        if (bus_req.rd) begin
            if (bus_req.addr == PMC_OFFSET) begin
                next_rdata = pmc;
            end else if (bus_req.addr == STATUS_OFFSET) begin
                next_rdata[STAT_MODE_HI_BIT:STAT_MODE_LO_BIT] = mode;
                next_rdata[STAT_SETTLE_BIT] = (mode == MODE_SETTLE);
                next_rdata[STAT_SLOW_BIT]   = ctrl.cpu_clk_sub;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pmc   <= PMC_RESET;
            rdata <= 8'h00;
        end else begin
            pmc   <= next_pmc;
            rdata <= next_rdata;
        end
    end

    // --------------------------------------------------------------
    // mode sequencer
    // --------------------------------------------------------------
    always_comb begin
        next_mode       = mode;
        next_cnt        = cnt;
        next_wait_sel_q = wait_sel_q;
        next_slow_q     = slow_q;
        unique case (mode)
            MODE_ACTIVE: begin
                if (sleep_exec) begin
                    next_wait_sel_q = wait_sel;
                    next_slow_q     = slow_sel;
                    if (!deep_sel) begin
                        next_mode = MODE_SLEEP;
                    end else if (watch_enable) begin
                        next_mode = MODE_WATCH;
                    end else begin
                        next_mode = MODE_STANDBY;
                    end
                end
            end
            MODE_SUBACTIVE: begin
                if (sleep_exec) begin
                    next_wait_sel_q = wait_sel;
                    next_slow_q     = slow_sel;
                    if (!deep_sel) begin
                        next_mode = MODE_SUBSLEEP;
                    end else begin
                        next_mode = MODE_WATCH;
                    end
                end
            end
            MODE_SLEEP: begin
                if (wake_irq) begin
                    next_mode = MODE_ACTIVE;
                end
            end
            MODE_SUBSLEEP: begin
                if (wake_irq) begin
                    next_mode = MODE_SUBACTIVE;
                end
            end
            MODE_STANDBY: begin
                if (wake_irq) begin
                    next_mode = MODE_SETTLE;
                    next_cnt  = wait_load(wait_sel_q);
                end
            end
            MODE_WATCH: begin
                if (wake_irq) begin
                    if (slow_q) begin
                        next_mode = MODE_SUBACTIVE;
                    end else begin
                        next_mode = MODE_SETTLE;
                        next_cnt  = wait_load(wait_sel_q);
                    end
                end
            end
            MODE_SETTLE: begin
                if (cnt == '0) begin
                    next_mode = MODE_ACTIVE;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            default: begin
                next_mode = MODE_ACTIVE;
            end
        endcase
    end

    // outputs follow the next mode so they line up with the mode register
    always_comb begin
        next_ctrl.cpu_run     = (next_mode == MODE_ACTIVE) ||
                                (next_mode == MODE_SUBACTIVE);
        next_ctrl.periph_run  = next_ctrl.cpu_run ||
                                (next_mode == MODE_SLEEP) ||
                                (next_mode == MODE_SUBSLEEP);
        next_ctrl.cpu_clk_sub = (next_mode == MODE_SUBACTIVE) ||
                                (next_mode == MODE_SUBSLEEP);
        next_ctrl.main_osc_on = (next_mode == MODE_ACTIVE) ||
                                (next_mode == MODE_SLEEP) ||
                                (next_mode == MODE_SETTLE);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode       <= MODE_ACTIVE;
            cnt        <= '0;
            wait_sel_q <= 3'h0;
            slow_q     <= 1'b0;
            ctrl       <= '{cpu_run: 1'b1, periph_run: 1'b1,
                            cpu_clk_sub: 1'b0, main_osc_on: 1'b1};
        end else begin
            mode       <= next_mode;
            cnt        <= next_cnt;
            wait_sel_q <= next_wait_sel_q;
            slow_q     <= next_slow_q;
            ctrl       <= next_ctrl;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic settle_prev;
    logic settle_entry;

    // marks the first cycle of settling, where the load is visible
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settle_prev <= 1'b0;
        end else begin
            settle_prev <= (mode == MODE_SETTLE);
        end
    end

    assign settle_entry = (mode == MODE_SETTLE) && !settle_prev;

    a_light_sleep_entry: assert property (
        sleep_exec && !deep_sel &&
        (mode == MODE_ACTIVE || mode == MODE_SUBACTIVE)
        |=> (mode == MODE_SLEEP && $past(mode) == MODE_ACTIVE) ||
            (mode == MODE_SUBSLEEP && $past(mode) == MODE_SUBACTIVE))
        else $error("light sleep entry wrong");

    a_sleep_controls: assert property (
        mode == MODE_SLEEP || mode == MODE_SUBSLEEP
        |-> ctrl.periph_run && !ctrl.cpu_run)
        else $error("sleep controls wrong");

    a_deep_sleep_entry: assert property (
        sleep_exec && deep_sel && mode == MODE_SUBACTIVE
        |=> mode == MODE_WATCH ##0 ctrl.cpu_run == 1'b0)
        else $error("subactive deep sleep did not enter watch");

    a_standby_entry: assert property (
        sleep_exec && deep_sel && mode == MODE_ACTIVE
        |=> mode == ($past(watch_enable) ? MODE_WATCH : MODE_STANDBY))
        else $error("active deep sleep target wrong");

    a_settle_hold: assert property (
        mode == MODE_SETTLE |-> !ctrl.cpu_run && !ctrl.periph_run)
        else $error("cpu released during settling");

    a_settle_osc_on: assert property (
        mode == MODE_SETTLE |-> ctrl.main_osc_on && !ctrl.cpu_clk_sub)
        else $error("oscillator off during settling");

    a_wait_zero_code: assert property (
        settle_entry && wait_sel_q == 3'h0
        |-> cnt == CNT_W'(WAIT_000 - 1))
        else $error("base wait load wrong");

    a_wait_long_codes: assert property (
        settle_entry && wait_sel_q == 3'h1
        |-> cnt == CNT_W'(WAIT_001 - 1))
        else $error("long wait load wrong");

    a_wait_mid_codes: assert property (
        settle_entry && wait_sel_q == 3'h2
        |-> cnt == CNT_W'(WAIT_010_CYC - 1))
        else $error("mid wait load wrong");

    a_wait_short_codes: assert property (
        settle_entry && wait_sel_q == 3'h5
        |-> cnt == 15'h0001 ##1 mode == MODE_SETTLE ##1
            mode == MODE_ACTIVE)
        else $error("short wait length wrong");

    a_watch_main_exit: assert property (
        mode == MODE_WATCH && wake_irq && !slow_q
        |=> mode == MODE_SETTLE && !ctrl.cpu_clk_sub)
        else $error("watch exit to main clock wrong");

    a_watch_sub_exit: assert property (
        mode == MODE_WATCH && wake_irq && slow_q
        |=> mode == MODE_SUBACTIVE && ctrl.cpu_clk_sub && ctrl.cpu_run)
        else $error("watch exit to subclock wrong");

    a_settle_release: assert property (
        mode == MODE_SETTLE && cnt != '0 |=> mode == MODE_SETTLE)
        else $error("settling ended before expiry");

    a_settle_expiry: assert property (
        mode == MODE_SETTLE && cnt == '0
        |=> mode == MODE_ACTIVE && ctrl.cpu_run)
        else $error("settling did not end at expiry");

    a_mode_hold: assert property (
        mode == MODE_ACTIVE && !sleep_exec |=> mode == MODE_ACTIVE)
        else $error("mode changed without sleep");

    a_select_sampled: assert property (
        mode != MODE_ACTIVE && mode != MODE_SUBACTIVE
        |=> $stable(wait_sel_q) && $stable(slow_q))
        else $error("selection changed while asleep");

endmodule : lpmc_ctrl

// ---- lpmc_ctrl_test.sv ----
`timescale 1ns/1ns
module lpmc_ctrl_test;
    import lpmc_pkg::*;

    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    localparam int W0    = 20;
    localparam int W1    = 40;
    localparam int LIMIT = 20000;

    logic          core_clk;
    logic          resetn;
    lpmc_bus_req_s bus_req;
    logic [7:0]    rdata;
    logic          sleep_exec;
    logic          wake_irq;
    logic          watch_enable;
    lpmc_mode_e    mode;
    lpmc_ctrl_s    ctrl;
    int            err_total;
    int            samples_checked;
    int            cycles;
    int            wexp [8];

    lpmc_ctrl #(.WAIT_000(W0), .WAIT_001(W1)) i_lpmc_ctrl (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .bus_req      (bus_req),
        .rdata        (rdata),
        .sleep_exec   (sleep_exec),
        .wake_irq     (wake_irq),
        .watch_enable (watch_enable),
        .mode         (mode),
        .ctrl         (ctrl)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            test_done();
        end
    end

    // --------------------------------------------------------------
    // report and compare
    // --------------------------------------------------------------
    task automatic test_done();
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic fail(input string msg);
        err_total++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk8(input logic [7:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) fail(msg);
    endtask : chk8

    task automatic chkm(input lpmc_mode_e got, exp, input string msg);
        samples_checked++;
        if (got !== exp) fail(msg);
    endtask : chkm

    task automatic chkn(input int got, exp, input string msg);
        samples_checked++;
        if (got != exp) fail(msg);
    endtask : chkn

    // expected run, periph, subclock, oscillator per mode
    function automatic logic [3:0] ctrl_of(input lpmc_mode_e m);
        case (m)
            MODE_ACTIVE:    ctrl_of = 4'hD;
            MODE_SLEEP:     ctrl_of = 4'h5;
            MODE_SUBACTIVE: ctrl_of = 4'hE;
            MODE_SUBSLEEP:  ctrl_of = 4'h6;
            MODE_SETTLE:    ctrl_of = 4'h1;
            default:        ctrl_of = 4'h0;
        endcase
    endfunction : ctrl_of

    task automatic state(input lpmc_mode_e m);
        chkm(mode, m, "mode");
        chk8({4'h0, ctrl}, {4'h0, ctrl_of(m)}, "power controls");
    endtask : state

    // --------------------------------------------------------------
    // access tasks
    // --------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        chk8(rdata, e, "read data");
        @(negedge core_clk);
        chk8(rdata, 8'h00, "read data after its cycle");
    endtask : rd

    // one-cycle sleep or wake pulse, ends where the new mode is settled
    task automatic ev(input logic wake);
        @(posedge core_clk);
        sleep_exec <= ~wake;
        wake_irq   <= wake;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        wake_irq   <= 1'b0;
        @(negedge core_clk);
    endtask : ev

    task automatic nap(input logic [7:0] cfg, input logic we,
                       input lpmc_mode_e m);
        wr(PMC_OFFSET, cfg);
        watch_enable <= we;
        ev(1'b0);
        state(m);
    endtask : nap

    task automatic settle(input int w);
        int n;
        n = 0;
        ev(1'b1);
        state(MODE_SETTLE);
        if (w > 8) begin
            rd(STATUS_OFFSET, 8'h0E);
            n = 3;
        end
        while (mode === MODE_SETTLE && n < LIMIT) begin
            n++;
            @(negedge core_clk);
        end
        chkn(n, w, "settle length");
    endtask : settle

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        wexp = '{W0, W1, WAIT_010_CYC, WAIT_011_CYC, WAIT_100_CYC,
                 WAIT_101_CYC, WAIT_110_CYC, WAIT_111_CYC};
        bus_req         = '0;
        sleep_exec      = 1'b0;
        wake_irq        = 1'b0;
        watch_enable    = 1'b0;
        resetn          = 1'b0;
        err_total       = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(negedge core_clk);
        state(MODE_ACTIVE);
        rd(PMC_OFFSET, PMC_RESET);
        wr(PMC_OFFSET, 8'hFF);
        rd(PMC_OFFSET, 8'hF8);
        state(MODE_ACTIVE);
        wr(STATUS_OFFSET, 8'hFF);
        rd(STATUS_OFFSET, 8'h00);
        wr(16'hFFF4, 8'h55);
        rd(16'hFFF4, 8'h00);
        nap(8'h00, 1'b0, MODE_SLEEP);
        ev(1'b1);
        state(MODE_ACTIVE);
        for (int c = 0; c < 8; c++) begin
            nap({1'b1, c[2:0], 4'h0}, 1'b0, MODE_STANDBY);
            settle(wexp[c]);
            state(MODE_ACTIVE);
        end
        nap(8'hD0, 1'b0, MODE_STANDBY);
        wr(PMC_OFFSET, 8'h60);
        state(MODE_STANDBY);
        rd(STATUS_OFFSET, 8'h02);
        settle(wexp[5]);
        nap(8'hF0, 1'b1, MODE_WATCH);
        settle(wexp[7]);
        state(MODE_ACTIVE);
        nap(8'hF8, 1'b1, MODE_WATCH);
        ev(1'b1);
        state(MODE_SUBACTIVE);
        rd(STATUS_OFFSET, 8'h14);
        nap(8'h08, 1'b0, MODE_SUBSLEEP);
        ev(1'b1);
        state(MODE_SUBACTIVE);
        nap(8'h88, 1'b0, MODE_WATCH);
        ev(1'b1);
        state(MODE_SUBACTIVE);
        nap(8'h80, 1'b0, MODE_WATCH);
        settle(wexp[0]);
        state(MODE_ACTIVE);
        test_done();
    end

endmodule : lpmc_ctrl_test

// ---- lpmc_pkg.sv ----
package lpmc_pkg;

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [15:0] PMC_OFFSET    = 16'hFFF0;
    localparam logic [15:0] STATUS_OFFSET = 16'hFFF2;
    localparam logic [7:0]  PMC_RESET     = 8'h00;

    localparam int DEEP_SLEEP_BIT   = 7;
    localparam int WAIT_SEL_HI_BIT  = 6;
    localparam int WAIT_SEL_LO_BIT  = 4;
    localparam int SLOW_ON_WAKE_BIT = 3;

    localparam int STAT_MODE_LO_BIT = 0;
    localparam int STAT_MODE_HI_BIT = 2;
    localparam int STAT_SETTLE_BIT  = 3;
    localparam int STAT_SLOW_BIT    = 4;

    // --------------------------------------------------------------
    // timing: one state is one system clock period
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int STATE_PERIOD_NS = 8;

    function automatic int st2cyc(input int states);
        st2cyc = (states * STATE_PERIOD_NS + CLK_PERIOD_NS - 1)
                 / CLK_PERIOD_NS;
    endfunction : st2cyc

    localparam int WAIT_000_ST = 8192;
    localparam int WAIT_001_ST = 16384;
    localparam int WAIT_010_ST = 1024;
    localparam int WAIT_011_ST = 2048;
    localparam int WAIT_100_ST = 4096;
    localparam int WAIT_101_ST = 2;
    localparam int WAIT_110_ST = 8;
    localparam int WAIT_111_ST = 16;

    localparam int WAIT_000_CYC = st2cyc(WAIT_000_ST);
    localparam int WAIT_001_CYC = st2cyc(WAIT_001_ST);
    localparam int WAIT_010_CYC = st2cyc(WAIT_010_ST);
    localparam int WAIT_011_CYC = st2cyc(WAIT_011_ST);
    localparam int WAIT_100_CYC = st2cyc(WAIT_100_ST);
    localparam int WAIT_101_CYC = st2cyc(WAIT_101_ST);
    localparam int WAIT_110_CYC = st2cyc(WAIT_110_ST);
    localparam int WAIT_111_CYC = st2cyc(WAIT_111_ST);

    localparam int CNT_W = 15;

    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_WATCH,
        MODE_SUBACTIVE,
        MODE_SUBSLEEP,
        MODE_SETTLE
    } lpmc_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } lpmc_bus_req_s;

    typedef struct packed {
        logic cpu_run;
        logic periph_run;
        logic cpu_clk_sub;
        logic main_osc_on;
    } lpmc_ctrl_s;

endpackage : lpmc_pkg
